// [rate_interval_divider.v]
/*
  Converts a rate in beats per minute into a pulse spacing in milliseconds
  by a restoring division that runs over and over, one bit per clock.
  Assumes the rate is held steady by its owner; a rate of zero acts as one.
*/
`timescale 1ns/1ps
`include "temp_stim_regs.vh"

module rate_interval_divider (
  input  wire        clock,
  input  wire        rst,
  input  wire [7:0]  rate,
  output reg  [15:0] intervalMs
);

  reg [15:0] quotient_reg;
  reg [15:0] remainder_reg;
  reg [15:0] dividend_reg;
  reg [7:0]  divisor_reg;
  reg [4:0]  bitCount_reg;
  wire [16:0] trial;

  // Shift next dividend bit into the partial remainder
  assign trial = {remainder_reg, dividend_reg[15]} - {9'h000, divisor_reg};

  always @(posedge clock) begin
    if (rst) begin
      quotient_reg  <= 16'h0000;
      remainder_reg <= 16'h0000;
      dividend_reg  <= 16'h0000;
      divisor_reg   <= 8'h01;
      bitCount_reg  <= 5'h00;
      intervalMs    <= `MS_PER_MINUTE;
    end else if (bitCount_reg == 5'h00) begin
      quotient_reg  <= 16'h0000;
      remainder_reg <= 16'h0000;
      dividend_reg  <= `MS_PER_MINUTE;
      divisor_reg   <= (rate == 8'h00) ? 8'h01 : rate;
      bitCount_reg  <= 5'h10;
    end else begin
      dividend_reg <= {dividend_reg[14:0], 1'b0};
      if (!trial[16]) begin
        remainder_reg <= trial[15:0];
        quotient_reg  <= {quotient_reg[14:0], 1'b1};
      end else begin
        remainder_reg <= {remainder_reg[14:0], dividend_reg[15]};
        quotient_reg  <= {quotient_reg[14:0], 1'b0};
      end
      bitCount_reg <= bitCount_reg - 5'h01;
      if (bitCount_reg == 5'h01) begin
        intervalMs <= (!trial[16]) ? {quotient_reg[14:0], 1'b1} : {quotient_reg[14:0], 1'b0};
      end
    end
  end

endmodule

// [tb_temp_stim_pattern_sequencer.sv]
/*
  Self-checking bench of the stimulation sequencer with a programmer model.
  Assumes a millisecond tick of 10 clocks, set through MS_TICK_CYCLES.
*/
`timescale 1ns/1ps
`include "temp_stim_regs.vh"
module tb_temp_stim_pattern_sequencer;
  localparam int TICK = 10;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        ventSense = 1'b0;
  wire  [7:0]  address;
  wire  [15:0] writeData, readData;
  wire         writeStrobe, readStrobe, linkPresent;
  wire         sessionActive, permanentProgramActive, backupPace, burstPace, progPace;
  wire  [1:0]  progStimIndex;
  wire         burstActive, progActive;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          t0, t1;
  logic [15:0] rdv;
  always #5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  temp_stim_pattern_sequencer #(.MS_TICK_CYCLES(TICK)) uut (
    .clock(clock), .rst(rst), .address(address), .writeData(writeData),
    .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
    .linkPresent(linkPresent), .ventSense(ventSense), .sessionActive(sessionActive),
    .permanentProgramActive(permanentProgramActive), .backupPace(backupPace),
    .burstPace(burstPace), .progPace(progPace), .progStimIndex(progStimIndex),
    .burstActive(burstActive), .progActive(progActive));
  telemetry_programmer host (
    .clock(clock), .readData(readData), .address(address), .writeData(writeData),
    .writeStrobe(writeStrobe), .readStrobe(readStrobe), .linkPresent(linkPresent));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s: %h not %h", $time, m, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic pulse_of(input int sel);
    return sel == 0 ? backupPace : (sel == 1 ? burstPace : progPace);
  endfunction
  task automatic wait_pulse(input int sel, input int lim, output int t);
    for (int i = 0; i < lim; i++) begin
      @(posedge clock);
      #1;
      if (pulse_of(sel) === 1'b1) begin
        t = cyc;
        return;
      end
    end
    num_errors++;
    $display("MISMATCH t=%0t pulse wait timed out", $time);
    tally_and_finish;
  endtask
  task automatic quiet(input int sel, input int n, input string m);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clock);
      #1;
      seen = seen | pulse_of(sel);
    end
    check(seen, 1'b0, m);
  endtask
  task automatic near(input int gap, input int exp, input string m);
    check(gap >= exp - TICK && gap <= exp + TICK, 1'b1, m);
  endtask
  task automatic scen_reset;
    host.rd(`OFS_STATUS, rdv);
    check(rdv, {`RST_BURST_START, 8'h00}, "status");
    host.rd(`OFS_BACKUP_RATE, rdv);
    check(rdv, 16'h003c, "backup rate");
    host.rd(`OFS_COMMAND, rdv);
    check(rdv, 16'h0000, "command");
    host.rd(8'h30, rdv);
    check(rdv, 16'h0000, "unmapped");
    host.wr(`OFS_HOLD, 16'h0001);
    host.rd(`OFS_HOLD, rdv);
    check(rdv, 16'h0000, "hold outside session");
    check(permanentProgramActive, 1'b1, "permanent");
  endtask
  task automatic scen_backup;
    host.wr(`OFS_BACKUP_RATE, 16'h00c8);
    host.start_session;
    check(sessionActive, 1'b1, "session");
    check(permanentProgramActive, 1'b0, "permanent");
    wait_pulse(0, 12000, t0);
    wait_pulse(0, 4000, t1);
    near(t1 - t0, 300 * TICK, "backup gap");
    repeat (4) begin
      @(posedge clock);
      ventSense <= 1'b1;
      @(posedge clock);
      ventSense <= 1'b0;
      quiet(0, 2000, "inhibited");
    end
  endtask
  task automatic scen_burst;
    host.wr(`OFS_BURST_START, 16'h00fa);
    repeat (20) @(posedge clock);
    host.wr(`OFS_HOLD, 16'h0001);
    check(burstActive, 1'b1, "burst active");
    wait_pulse(1, 3000, t0);
    wait_pulse(1, 3000, t1);
    near(t1 - t0, 240 * TICK, "burst gap");
    host.wr(`OFS_BACKUP_RATE, 16'h0064);
    host.rd(`OFS_BACKUP_RATE, rdv);
    check(rdv, 16'h00c8, "frozen rate");
    host.wr(`OFS_HOLD, 16'h0000);
    check(burstActive, 1'b0, "burst off");
    quiet(1, 3000, "burst stopped");
  endtask
  task automatic ramp(input logic [15:0] hold, input logic [7:0] r1, input logic [7:0] r2);
    host.wr(`OFS_HOLD, hold);
    repeat (1500) @(posedge clock);
    host.rd(`OFS_STATUS, rdv);
    check(rdv[15:8], r1, "one step");
    repeat (2500) @(posedge clock);
    host.rd(`OFS_STATUS, rdv);
    check(rdv[15:8], r2, "saturated");
    host.wr(`OFS_HOLD, 16'h0000);
    repeat (2) @(posedge clock);
    host.rd(`OFS_STATUS, rdv);
    check(rdv[15:8], 8'hfa, "back to start");
  endtask
  task automatic run_prog(input int n, input int c1, input int c2, input int c3,
                          input int cnt);
    int cpl[3];
    int last, t, ex;
    cpl = '{c1, c2, c3};
    host.wr(`OFS_BASIC_CYCLES, 16'(n));
    host.wr(`OFS_FIRST_COUPLING, 16'(c1));
    host.wr(`OFS_SECOND_COUPLING, 16'(c2));
    host.wr(`OFS_THIRD_COUPLING, 16'(c3));
    host.wr(`OFS_COMMAND, 16'h0004);
    for (int k = 0; k < cnt; k++) begin
      if (k > 0) begin
        wait_pulse(2, 2000, t);
      end else begin
        check(progPace, 1'b1, "first stimulus");
        t = cyc;
      end
      ex = k <= n ? 0 : k - n;
      check(progStimIndex, 16'(ex), "index");
      ex = k <= n ? 20 * TICK : cpl[k - n - 1] * TICK;
      if (k > 0) near(t - last, ex, "stimulus gap");
      last = t;
    end
    quiet(2, 600, "no further stimulus");
    check(progActive, 1'b0, "sequence done");
  endtask
  task automatic scen_prog_stop;
    host.wr(`OFS_BASIC_CYCLES, 16'h0008);
    host.wr(`OFS_COMMAND, 16'h0004);
    check(progPace, 1'b1, "first stimulus");
    host.wr(`OFS_COMMAND, 16'h0008);
    check(progActive, 1'b0, "stopped");
    quiet(2, 500, "no stimulus after stop");
  endtask
  task automatic scen_end;
    host.wr(`OFS_COMMAND, 16'h0002);
    check(sessionActive, 1'b0, "stop");
    quiet(0, 3500, "no backup");
    host.start_session;
    host.set_link(1'b0);
    host.set_link(1'b1);
    check(sessionActive, 1'b0, "link lost");
    check(permanentProgramActive, 1'b1, "permanent");
    quiet(0, 3500, "no backup");
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    scen_reset;
    scen_backup;
    scen_burst;
    host.wr(`OFS_BURST_MAX, 16'h00fc);
    host.wr(`OFS_BURST_MIN, 16'h00f8);
    ramp(16'h0003, 8'hfb, 8'hfc);
    ramp(16'h0005, 8'hf9, 8'hf8);
    host.wr(`OFS_BASIC_INTERVAL, 16'h0014);
    run_prog(2, 15, 12, 10, 6);
    run_prog(0, 15, 0, 10, 2);
    run_prog(1, 0, 12, 10, 2);
    run_prog(0, 15, 12, 0, 3);
    scen_prog_stop;
    scen_end;
    tally_and_finish;
  end
endmodule

// [telemetry_programmer.sv]
/*
  Programmer model: drives the register port and the telemetry link.
  Assumes the sequencer takes strobes on the rising clock edge.
*/
`timescale 1ns/1ps
`include "temp_stim_regs.vh"
module telemetry_programmer (
  input  wire         clock,
  input  wire  [15:0] readData,
  output logic [7:0]  address,
  output logic [15:0] writeData,
  output logic        writeStrobe,
  output logic        readStrobe,
  output logic        linkPresent
);
  initial begin
    address = 8'h00;
    writeData = 16'h0000;
    writeStrobe = 1'b0;
    readStrobe = 1'b0;
    linkPresent = 1'b1;
  end
  // Released bus lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
    address <= ~a;
    writeData <= ~d;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    address <= a;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    address <= ~a;
    #1;
    d = readData;
  endtask
  // Opens the session before any hold or sequence command
  task automatic start_session;
    wr(`OFS_COMMAND, 16'h0001);
  endtask
  task automatic set_link(input logic up);
    @(posedge clock);
    linkPresent <= up;
    #1;
  endtask
endmodule

// [temp_stim_pattern_sequencer.v]
/*
  Temporary stimulation session: backup inhibited ventricular pacing, burst
  pacing with rate ramp, and programmed stimulation with three extrastimuli.
  Assumes a 100 MHz clock, synchronous inputs, and a programmer that writes
  commands through the plain register port.
*/
// Overview of operation
// - Start command opens session with backup pacing
// - Backup inhibited pacing, rate frozen during stimulation
// - Stop command returns to permanent program
// - Burst pulses while hold asserted
// - Releasing hold stops burst at once
// - Increase hold ramps rate up to maximum
// - Decrease hold ramps rate down to minimum
// - Ramp slope fixed at 10 bpm per second
// - Basic drive plus at most three extrastimuli
// - Basic drive repeats for basic cycle count
// - Zero cycles: extrastimuli follow first basic stimulus
// - No first/second coupling cancels later extrastimuli
// - First extrastimulus after first coupling interval
// - Second extrastimulus after second coupling interval
// - Third extrastimulus after third coupling interval
// - Sequence runs until complete, manual stop or session end
// - Lost telemetry link ends the session
`timescale 1ns/1ps
`include "temp_stim_regs.vh"

module temp_stim_pattern_sequencer #(
  parameter MS_TICK_CYCLES = `MS_TICK_CYCLES
) (
  input  wire        clock,
  input  wire        rst,
  input  wire [7:0]  address,
  input  wire [15:0] writeData,
  input  wire        writeStrobe,
  input  wire        readStrobe,
  output reg  [15:0] readData,
  input  wire        linkPresent,
  input  wire        ventSense,
  output reg         sessionActive,
  output wire        permanentProgramActive,
  output reg         backupPace,
  output reg         burstPace,
  output reg         progPace,
  output reg  [1:0]  progStimIndex,
  output wire        burstActive,
  output wire        progActive
);

  localparam P_IDLE  = 3'h0;
  localparam P_BASIC = 3'h1;
  localparam P_CPL1  = 3'h2;
  localparam P_CPL2  = 3'h3;
  localparam P_CPL3  = 3'h4;

  reg  [7:0]  backupRate_reg;
  reg  [7:0]  burstStart_reg;
  reg  [7:0]  burstMin_reg;
  reg  [7:0]  burstMax_reg;
  reg  [15:0] basicInterval_reg;
  reg  [7:0]  basicCycles_reg;
  reg  [15:0] firstCoupling_reg;
  reg  [15:0] secondCoupling_reg;
  reg  [15:0] thirdCoupling_reg;
  reg  [2:0]  hold_reg;
  reg  [7:0]  burstRate_reg;
  reg  [16:0] tickCount_reg;
  reg         msTick;
  reg  [15:0] backupElapsed_reg;
  reg  [15:0] burstElapsed_reg;
  reg  [7:0]  rampElapsed_reg;
  reg  [2:0]  progState_reg;
  reg  [2:0]  progState_next;
  reg  [15:0] progElapsed_reg;
  reg  [7:0]  progRepeats_reg;
  reg  [15:0] progTarget;
  reg  [2:0]  afterBasic;
  reg  [2:0]  afterCoupling;
  wire [15:0] backupInterval;
  wire [15:0] burstInterval;
  wire        cmdWrite;
  wire        startBackup;
  wire        stopBackup;
  wire        startProg;
  wire        stopProg;
  wire        rampUp;
  wire        rampDown;
  wire        progFire;
  wire [15:0] statusWord;

  assign cmdWrite    = writeStrobe && (address == `OFS_COMMAND);
  assign startBackup = cmdWrite && writeData[`CMD_START_BACKUP_BIT];
  assign stopBackup  = cmdWrite && writeData[`CMD_STOP_BACKUP_BIT];
  assign startProg   = cmdWrite && writeData[`CMD_START_PROG_BIT] && sessionActive;
  assign stopProg    = cmdWrite && writeData[`CMD_STOP_PROG_BIT];

  assign permanentProgramActive = !sessionActive;
  assign burstActive = sessionActive && hold_reg[`HOLD_BURST_BIT];
  assign progActive  = (progState_reg != P_IDLE);
  assign rampUp      = burstActive && hold_reg[`HOLD_INCREASE_BIT] && !hold_reg[`HOLD_DECREASE_BIT];
  assign rampDown    = burstActive && hold_reg[`HOLD_DECREASE_BIT] && !hold_reg[`HOLD_INCREASE_BIT];

  // Session: link loss wins, then a start in the same write wins over stop
  always @(posedge clock) begin
    if (rst) begin
      sessionActive <= 1'b0;
    end else if (!linkPresent) begin
      sessionActive <= 1'b0;
    end else if (startBackup) begin
      sessionActive <= 1'b1;
    end else if (stopBackup) begin
      sessionActive <= 1'b0;
    end
  end

  // Configuration registers; backup rate frozen while stimulation runs
  always @(posedge clock) begin
    if (rst) begin
      backupRate_reg     <= `RST_BACKUP_RATE;
      burstStart_reg     <= `RST_BURST_START;
      burstMin_reg       <= `RST_BURST_MIN;
      burstMax_reg       <= `RST_BURST_MAX;
      basicInterval_reg  <= `RST_BASIC_INTERVAL;
      basicCycles_reg    <= `RST_BASIC_CYCLES;
      firstCoupling_reg  <= `RST_COUPLING;
      secondCoupling_reg <= `RST_COUPLING;
      thirdCoupling_reg  <= `RST_COUPLING;
    end else if (writeStrobe) begin
      case (address)
        `OFS_BACKUP_RATE: begin
          if (!burstActive && !progActive) begin
            backupRate_reg <= writeData[7:0];
          end
        end
        `OFS_BURST_START:     burstStart_reg     <= writeData[7:0];
        `OFS_BURST_MIN:       burstMin_reg       <= writeData[7:0];
        `OFS_BURST_MAX:       burstMax_reg       <= writeData[7:0];
        `OFS_BASIC_INTERVAL:  basicInterval_reg  <= writeData;
        `OFS_BASIC_CYCLES:    basicCycles_reg    <= writeData[7:0];
        `OFS_FIRST_COUPLING:  firstCoupling_reg  <= writeData;
        `OFS_SECOND_COUPLING: secondCoupling_reg <= writeData;
        `OFS_THIRD_COUPLING:  thirdCoupling_reg  <= writeData;
        default: begin
        end
      endcase
    end
  end

  // Hold levels only count inside a session and drop when it ends
  always @(posedge clock) begin
    if (rst) begin
      hold_reg <= 3'h0;
    end else if (!sessionActive || !linkPresent || stopBackup) begin
      hold_reg <= 3'h0;
    end else if (writeStrobe && (address == `OFS_HOLD)) begin
      hold_reg <= writeData[2:0];
    end
  end

  // Millisecond time base
  always @(posedge clock) begin
    if (rst) begin
      tickCount_reg <= 17'h00000;
      msTick        <= 1'b0;
    end else if ({15'h0000, tickCount_reg} == MS_TICK_CYCLES - 1) begin
      tickCount_reg <= 17'h00000;
      msTick        <= 1'b1;
    end else begin
      tickCount_reg <= tickCount_reg + 17'h00001;
      msTick        <= 1'b0;
    end
  end

  rate_interval_divider backupDivider (
    .clock      (clock),
    .rst        (rst),
    .rate       (backupRate_reg),
    .intervalMs (backupInterval)
  );

  rate_interval_divider burstDivider (
    .clock      (clock),
    .rst        (rst),
    .rate       (burstRate_reg),
    .intervalMs (burstInterval)
  );

  // Backup escape timer, restarted by sensed or paced ventricular beats
  always @(posedge clock) begin
    if (rst) begin
      backupElapsed_reg <= 16'h0000;
      backupPace        <= 1'b0;
    end else if (!sessionActive || ventSense) begin
      backupElapsed_reg <= 16'h0000;
      backupPace        <= 1'b0;
    end else if (msTick && (backupElapsed_reg + 16'h0001 >= backupInterval)) begin
      backupElapsed_reg <= 16'h0000;
      backupPace        <= 1'b1;
    end else begin
      if (msTick) begin
        backupElapsed_reg <= backupElapsed_reg + 16'h0001;
      end
      backupPace <= 1'b0;
    end
  end

  // Burst rate: preset while idle, ramped one bpm per step while held
  always @(posedge clock) begin
    if (rst) begin
      burstRate_reg   <= `RST_BURST_START;
      rampElapsed_reg <= 8'h00;
    end else if (!burstActive) begin
      burstRate_reg   <= burstStart_reg;
      rampElapsed_reg <= 8'h00;
    end else if (!(rampUp || rampDown)) begin
      rampElapsed_reg <= 8'h00;
    end else if (msTick) begin
      if ({24'h000000, rampElapsed_reg} == `RAMP_STEP_MS - 1) begin
        rampElapsed_reg <= 8'h00;
        if (rampUp) begin
          if (burstRate_reg < burstMax_reg) begin
            burstRate_reg <= burstRate_reg + 8'h01;
          end else begin
            burstRate_reg <= burstMax_reg;
          end
        end else begin
          if (burstRate_reg > burstMin_reg) begin
            burstRate_reg <= burstRate_reg - 8'h01;
          end else begin
            burstRate_reg <= burstMin_reg;
          end
        end
      end else begin
        rampElapsed_reg <= rampElapsed_reg + 8'h01;
      end
    end
  end

  // Burst pulses spaced by the reciprocal of the current rate
  always @(posedge clock) begin
    if (rst) begin
      burstElapsed_reg <= 16'h0000;
      burstPace        <= 1'b0;
    end else if (!burstActive) begin
      burstElapsed_reg <= 16'h0000;
      burstPace        <= 1'b0;
    end else if (msTick && (burstElapsed_reg + 16'h0001 >= burstInterval)) begin
      burstElapsed_reg <= 16'h0000;
      burstPace        <= 1'b1;
    end else begin
      if (msTick) begin
        burstElapsed_reg <= burstElapsed_reg + 16'h0001;
      end
      burstPace <= 1'b0;
    end
  end

  // Programmed stimulation sequencing
  always @* begin
    afterBasic = (firstCoupling_reg != 16'h0000) ? P_CPL1 : P_IDLE;
    case (progState_reg)
      P_BASIC: progTarget = basicInterval_reg;
      P_CPL1:  progTarget = firstCoupling_reg;
      P_CPL2:  progTarget = secondCoupling_reg;
      P_CPL3:  progTarget = thirdCoupling_reg;
      default: progTarget = 16'h0000;
    endcase
    case (progState_reg)
      P_CPL1:  afterCoupling = (secondCoupling_reg != 16'h0000) ? P_CPL2 : P_IDLE;
      P_CPL2:  afterCoupling = (thirdCoupling_reg != 16'h0000) ? P_CPL3 : P_IDLE;
      default: afterCoupling = P_IDLE;
    endcase
  end

  assign progFire = msTick && (progState_reg != P_IDLE) && (progElapsed_reg + 16'h0001 >= progTarget);

  always @* begin
    progState_next = progState_reg;
    case (progState_reg)
      P_IDLE: begin
        if (startProg) begin
          progState_next = (basicCycles_reg == 8'h00) ? afterBasic : P_BASIC;
        end
      end
      P_BASIC: begin
        if (progFire && (progRepeats_reg + 8'h01 >= basicCycles_reg)) begin
          progState_next = afterBasic;
        end
      end
      P_CPL1, P_CPL2, P_CPL3: begin
        if (progFire) begin
          progState_next = afterCoupling;
        end
      end
      default: progState_next = P_IDLE;
    endcase
    if (stopProg || !sessionActive) begin
      progState_next = P_IDLE;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      progState_reg   <= P_IDLE;
      progElapsed_reg <= 16'h0000;
      progRepeats_reg <= 8'h00;
      progPace        <= 1'b0;
      progStimIndex   <= 2'h0;
    end else begin
      progState_reg <= progState_next;
      progPace      <= 1'b0;
      if (progState_reg == P_IDLE) begin
        progElapsed_reg <= 16'h0000;
        progRepeats_reg <= 8'h00;
        if (startProg && !stopProg) begin
          progPace      <= 1'b1;
          progStimIndex <= 2'h0;
        end
      end else if (stopProg || !sessionActive) begin
        progElapsed_reg <= 16'h0000;
      end else if (progFire) begin
        progElapsed_reg <= 16'h0000;
        progPace        <= 1'b1;
        case (progState_reg)
          P_BASIC: begin
            progRepeats_reg <= progRepeats_reg + 8'h01;
            progStimIndex   <= 2'h0;
          end
          P_CPL1:  progStimIndex <= 2'h1;
          P_CPL2:  progStimIndex <= 2'h2;
          P_CPL3:  progStimIndex <= 2'h3;
          default: progStimIndex <= 2'h0;
        endcase
      end else if (msTick) begin
        progElapsed_reg <= progElapsed_reg + 16'h0001;
      end
    end
  end

  // Read port, data valid the cycle after the strobe
  assign statusWord = {burstRate_reg, 2'h0, progState_reg, progActive, burstActive, sessionActive};

  always @(posedge clock) begin
    if (rst) begin
      readData <= 16'h0000;
    end else if (readStrobe) begin
      case (address)
        `OFS_HOLD:            readData <= {13'h0000, hold_reg};
        `OFS_BACKUP_RATE:     readData <= {8'h00, backupRate_reg};
        `OFS_BURST_START:     readData <= {8'h00, burstStart_reg};
        `OFS_BURST_MIN:       readData <= {8'h00, burstMin_reg};
        `OFS_BURST_MAX:       readData <= {8'h00, burstMax_reg};
        `OFS_BASIC_INTERVAL:  readData <= basicInterval_reg;
        `OFS_BASIC_CYCLES:    readData <= {8'h00, basicCycles_reg};
        `OFS_FIRST_COUPLING:  readData <= firstCoupling_reg;
        `OFS_SECOND_COUPLING: readData <= secondCoupling_reg;
        `OFS_THIRD_COUPLING:  readData <= thirdCoupling_reg;
        `OFS_STATUS:          readData <= statusWord;
        default:              readData <= 16'h0000;
      endcase
    end else begin
      readData <= 16'h0000;
    end
  end

endmodule

// [temp_stim_pattern_sequencer_chk.sv]
/*
  Port assertions of the stimulation sequencer.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "temp_stim_regs.vh"
module temp_stim_pattern_sequencer_chk #(
  parameter MS_TICK_CYCLES = `MS_TICK_CYCLES
) (
  input wire        clock,
  input wire        rst,
  input wire [7:0]  address,
  input wire [15:0] writeData,
  input wire        writeStrobe,
  input wire        linkPresent,
  input wire        sessionActive,
  input wire        permanentProgramActive,
  input wire        backupPace,
  input wire        burstPace,
  input wire        progPace,
  input wire        burstActive,
  input wire        progActive
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  AST_SESSION_START: assert property (writeStrobe && address == `OFS_COMMAND &&
    writeData[0] && linkPresent |=> sessionActive) else $error("session not opened");
  AST_SESSION_STOP: assert property (writeStrobe && address == `OFS_COMMAND &&
    writeData[1] && !writeData[0] |=> !sessionActive) else $error("session not closed");
  AST_PERM_PROGRAM: assert property (permanentProgramActive == !sessionActive)
    else $error("permanent program flag wrong");
  AST_LINK_LOSS: assert property (!linkPresent |=> !sessionActive)
    else $error("session kept without link");
  AST_BURST_HELD: assert property (burstPace |-> $past(burstActive))
    else $error("burst pulse without hold");
  AST_BURST_SESSION: assert property (burstActive |-> sessionActive)
    else $error("burst outside session");
  AST_BACKUP_SESSION: assert property (backupPace |-> $past(sessionActive))
    else $error("backup pace outside session");
  AST_BACKUP_PULSE: assert property (backupPace |=> !backupPace)
    else $error("backup pace longer than one cycle");
  AST_PROG_IN_SEQ: assert property (progPace |-> progActive || $past(progActive))
    else $error("stimulus outside sequence");
  AST_PROG_STOP: assert property (writeStrobe && address == `OFS_COMMAND &&
    writeData[3] && !writeData[2] |=> !progActive) else $error("sequence not stopped");
endmodule
bind temp_stim_pattern_sequencer temp_stim_pattern_sequencer_chk #(
  .MS_TICK_CYCLES(MS_TICK_CYCLES)
) chk (
  .clock(clock), .rst(rst), .address(address), .writeData(writeData),
  .writeStrobe(writeStrobe), .linkPresent(linkPresent), .sessionActive(sessionActive),
  .permanentProgramActive(permanentProgramActive), .backupPace(backupPace),
  .burstPace(burstPace), .progPace(progPace), .burstActive(burstActive),
  .progActive(progActive)
);

// [temp_stim_regs.vh]
/*
  Register offsets, field positions, reset values and timing counts of the
  temporary stimulation pattern sequencer.
  Assumes a 100 MHz clock and a 16-bit register port with byte addresses.
*/
`ifndef TEMP_STIM_REGS_VH
`define TEMP_STIM_REGS_VH

`define ADDR_WIDTH            8
`define DATA_WIDTH            16

`define OFS_COMMAND           8'h00
`define OFS_HOLD              8'h04
`define OFS_BACKUP_RATE       8'h08
`define OFS_BURST_START       8'h0c
`define OFS_BURST_MIN         8'h10
`define OFS_BURST_MAX         8'h14
`define OFS_BASIC_INTERVAL    8'h18
`define OFS_BASIC_CYCLES      8'h1c
`define OFS_FIRST_COUPLING    8'h20
`define OFS_SECOND_COUPLING   8'h24
`define OFS_THIRD_COUPLING    8'h28
`define OFS_STATUS            8'h2c

`define CMD_START_BACKUP_BIT  0
`define CMD_STOP_BACKUP_BIT   1
`define CMD_START_PROG_BIT    2
`define CMD_STOP_PROG_BIT     3

`define HOLD_BURST_BIT        0
`define HOLD_INCREASE_BIT     1
`define HOLD_DECREASE_BIT     2

`define STAT_SESSION_BIT      0
`define STAT_BURST_BIT        1
`define STAT_PROG_BIT         2
`define STAT_PHASE_LSB        3
`define STAT_PHASE_MSB        5
`define STAT_RATE_LSB         8
`define STAT_RATE_MSB         15

`define RST_BACKUP_RATE       8'h3c
`define RST_BURST_START       8'h78
`define RST_BURST_MIN         8'h50
`define RST_BURST_MAX         8'hc8
`define RST_BASIC_INTERVAL    16'h0258
`define RST_BASIC_CYCLES      8'h08
`define RST_COUPLING          16'h0000

`define CLOCK_HZ              100000000
`define MS_PER_SECOND         1000
`define MS_TICK_CYCLES        (`CLOCK_HZ / `MS_PER_SECOND)
`define MS_PER_MINUTE         16'hea60
`define RAMP_SLOPE_BPM_PER_S  10
`define RAMP_STEP_MS          (`MS_PER_SECOND / `RAMP_SLOPE_BPM_PER_S)

`endif
